// ==== core/sdc_sdram_core.sv ====
// Four-bank synchronous DRAM device core: commands, mode setting, bursts, data timing
// What this block and its controller do
// [R01] All pins sampled on rising clock edge
// [R02] Four banks, 8192 rows, 512 wide columns
// [R03] Activate picks bank and row; column starts burst
// [R04] Controller waits 100us with only idle commands
// [R05] Controller precharges all, then two auto-refreshes
// [R06] Controller loads mode setting before operation
// [R07] Mode setting held until next load
// [R08] Mode fields: length, order, latency, mode, policy
// [R09] Controller loads mode only with banks idle
// [R10] Controller waits two cycles after mode load
// [R11] Lengths 1,2,4,8; full page sequential only
// [R12] Burst wraps inside aligned length-sized column block
// [R13] Full page burst wraps within its row
// [R14] Controller spaces activate to column command
// [R15] Controller spaces activates to different banks
// [R16] Column commands accepted every cycle
// [R17] Burst stop floats read outputs after latency
// [R18] Burst stop drops same-cycle write data
// [R19] Precharge floats read outputs after latency
// [R20] Precharge drops same-cycle write data
// [R21] Mask: reads two cycles, writes zero cycles
// [R22] Read auto precharge starts before last output
// [R23] Read data valid by edge n plus latency
// [R24] Policy bit makes writes single-location
// [R25] Controller keeps operating mode bits zero
// [R26] Controller writes zeros to reserved bits
module sdc_sdram_core (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Command side
  input wire logic cke_i,
  input wire sdc_pkg::sdc_bus_s bus_i,
  // Data pins, split into input, output and enable
  input wire logic [sdc_pkg::DQ_W-1:0] dq_i,
  output logic [sdc_pkg::DQ_W-1:0] dq_o,
  output logic [sdc_pkg::LANES-1:0] dq_oe_n_o
);

  // Whole array, one word per bank, row and column
  logic [sdc_pkg::DQ_W-1:0] mem [0:(1 << sdc_pkg::MEM_AW)-1];

  sdc_pkg::sdc_state_s s_r;           // Registered state
  sdc_pkg::sdc_state_s s_nxt;         // Next state
  sdc_pkg::sdc_cmd_e cmd;             // Decoded command
  logic [sdc_pkg::BANK_W-1:0] cmd_bank; // Bank pins
  logic col_cmd;                      // Read or write this cycle
  logic stop;                         // Burst stop or precharge hitting the burst
  logic cur_wr;                       // Beat direction
  logic cur_ap;                       // Beat burst closes its row
  logic [sdc_pkg::BANK_W-1:0] cur_bank; // Beat bank
  logic [sdc_pkg::COL_W-1:0] cur_scol;  // Beat burst start column
  logic [sdc_pkg::COL_W-1:0] cur_idx;   // Beat index in burst
  logic [sdc_pkg::COL_W-1:0] len_mask;  // Burst length minus one
  logic [sdc_pkg::COL_W-1:0] beat_col;  // Column of this beat
  logic page;                         // Full-page burst
  logic last;                         // This beat ends the burst
  logic beat_on;                      // A data beat happens this cycle
  logic lat3;                         // Read latency of three
  logic [sdc_pkg::MEM_AW-1:0] beat_addr; // Array address of this beat
  logic [sdc_pkg::DQ_W-1:0] wr_word;  // Write word after lane masking
  logic mem_we;                       // Array write strobe

  assign cmd_bank = {bus_i.bank_select_high, bus_i.bank_select_low};
  assign lat3 = s_r.mode[sdc_pkg::READ_LAT_MSB:sdc_pkg::READ_LAT_LSB] == sdc_pkg::READ_LAT_3;

  // Command decode from the strobe pins; a deselected chip sees no operation
  always_comb begin
    unique case ({bus_i.cs_n, bus_i.ras_n, bus_i.cas_n, bus_i.we_n}) // see [R01]
      4'h3: cmd = sdc_pkg::CMD_ACT;
      4'h5: cmd = sdc_pkg::CMD_READ;
      4'h4: cmd = sdc_pkg::CMD_WRITE;
      4'h6: cmd = sdc_pkg::CMD_BST;
      4'h2: cmd = sdc_pkg::CMD_PRE;
      4'h1: cmd = sdc_pkg::CMD_REF;
      4'h0: cmd = sdc_pkg::CMD_LOAD;
      default: cmd = sdc_pkg::CMD_NOP;
    endcase
  end

  // Beat generation: a new column command starts at once, else the burst continues
  always_comb begin
    col_cmd = (cmd == sdc_pkg::CMD_READ) || (cmd == sdc_pkg::CMD_WRITE); // see [R16]
    stop = (cmd == sdc_pkg::CMD_BST) || ((cmd == sdc_pkg::CMD_PRE) &&
           (bus_i.addr[sdc_pkg::AUTO_PRE_BIT] || cmd_bank == s_r.bank)); // see [R18] [R20]
    if (col_cmd) begin
      // Column pins give the starting column of the burst
      cur_wr = cmd == sdc_pkg::CMD_WRITE;
      cur_ap = bus_i.addr[sdc_pkg::AUTO_PRE_BIT];
      cur_bank = cmd_bank;
      cur_scol = bus_i.addr[sdc_pkg::COL_W-1:0]; // see [R03]
      cur_idx = '0;
    end else begin
      cur_wr = s_r.wr;
      cur_ap = s_r.ap;
      cur_bank = s_r.bank;
      cur_scol = s_r.scol;
      cur_idx = s_r.idx;
    end
    page = 1'b0;
    case (s_r.mode[sdc_pkg::BURST_LEN_MSB:sdc_pkg::BURST_LEN_LSB]) // see [R11]
      sdc_pkg::BL_2: len_mask = 9'h001;
      sdc_pkg::BL_4: len_mask = 9'h003;
      sdc_pkg::BL_8: len_mask = 9'h007;
      sdc_pkg::BL_PAGE: begin
        len_mask = 9'h1FF;
        page = 1'b1;
      end
      // Length one and the reserved codes run single beats
      default: len_mask = 9'h000;
    endcase
    // Single-location writes when the policy bit is set
    if (cur_wr && s_r.mode[sdc_pkg::WRITE_BURST_POLICY_BIT]) begin // see [R24]
      len_mask = 9'h000;
      page = 1'b0;
    end
    // Interleave is unsupported on full page, so page always counts up
    if (s_r.mode[sdc_pkg::BURST_ORDER_BIT] && !page) begin
      beat_col = (cur_scol & ~len_mask) | ((cur_scol ^ cur_idx) & len_mask); // see [R12]
    end else begin
      beat_col = (cur_scol & ~len_mask) | (9'(cur_scol + cur_idx) & len_mask); // see [R12] [R13]
    end
    last = !page && (cur_idx == len_mask);
    // A column command to a closed bank moves no data
    if (col_cmd) begin
      beat_on = s_r.open[cmd_bank];
    end else begin
      beat_on = s_r.busy && !stop;
    end
    beat_addr = {cur_bank, s_r.row[cur_bank], beat_col}; // see [R02]
    mem_we = cke_i && beat_on && cur_wr;
  end

  // Write mask lanes apply in the same cycle as their data
  for (genvar g = 0; g < sdc_pkg::LANES; g++) begin : g_lane
    assign wr_word[g*8 +: 8] = bus_i.dqm[g] ? mem[beat_addr][g*8 +: 8] : dq_i[g*8 +: 8]; // see [R21]
  end

  // Array write port; the array holds no reset, like real cells
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      mem[beat_addr] <= wr_word;
    end
  end

  // Next-state logic for banks, mode setting, burst and read pipeline
  always_comb begin
    s_nxt = s_r;
    if (cke_i) begin
      // Bank and mode commands
      case (cmd)
        sdc_pkg::CMD_ACT: begin
          s_nxt.open[cmd_bank] = 1'b1;
          s_nxt.row[cmd_bank] = bus_i.addr; // see [R03]
        end
        sdc_pkg::CMD_PRE: begin
          if (bus_i.addr[sdc_pkg::AUTO_PRE_BIT]) begin
            s_nxt.open = '0;
          end else begin
            s_nxt.open[cmd_bank] = 1'b0;
          end
        end
        // Only a load changes the mode setting
        sdc_pkg::CMD_LOAD: s_nxt.mode = bus_i.addr; // see [R07] [R08]
        default: s_nxt.mode = s_r.mode;
      endcase
      // Pending read auto precharge counts down to its closing edge
      if (s_r.apc_v) begin
        if (s_r.apc_cnt == 2'h0) begin
          s_nxt.apc_v = 1'b0;
          s_nxt.open[s_r.apc_bank] = 1'b0; // see [R22]
        end else begin
          s_nxt.apc_cnt = s_r.apc_cnt - 2'h1;
        end
      end
      // Burst bookkeeping
      s_nxt.busy = beat_on && !last;
      s_nxt.wr = cur_wr;
      s_nxt.ap = cur_ap;
      s_nxt.bank = cur_bank;
      s_nxt.scol = cur_scol;
      s_nxt.idx = cur_idx + 9'h001;
      if (beat_on && last && cur_ap) begin
        if (cur_wr) begin
          // Write rows close with the last beat; recovery is the controller's wait
          s_nxt.open[cur_bank] = 1'b0;
        end else begin
          s_nxt.apc_v = 1'b1;
          s_nxt.apc_cnt = lat3 ? sdc_pkg::AP_WAIT_CL3 : sdc_pkg::AP_WAIT_CL2; // see [R22]
          s_nxt.apc_bank = cur_bank;
        end
      end
      // Read pipeline: fetch, optional stage, output register
      s_nxt.p1_v = beat_on && !cur_wr;
      s_nxt.p1_d = mem[beat_addr];
      s_nxt.p2_v = s_r.p1_v;
      s_nxt.p2_d = s_r.p1_d;
      s_nxt.dqm_d = bus_i.dqm;
      // A stopped burst leaves empty stages, floating the pins after the latency
      if (lat3 ? s_r.p2_v : s_r.p1_v) begin // see [R17] [R19] [R23]
        s_nxt.out_d = lat3 ? s_r.p2_d : s_r.p1_d;
        s_nxt.out_oe_n = s_r.dqm_d; // see [R21]
      end else begin
        s_nxt.out_oe_n = '1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{mode: sdc_pkg::MODE_RESET, out_oe_n: '1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data outputs straight from flip-flops
  assign dq_o = s_r.out_d;
  assign dq_oe_n_o = s_r.out_oe_n;

endmodule : sdc_sdram_core

// ==== include/sdc_pkg.sv ====
// Shared constants, command codes and carrier types of the SDRAM device core
package sdc_pkg;

  // Array organisation of the wide (16-bit) variant
  localparam int BANK_W = 2;   // Two bank-select bits
  localparam int ROW_W = 13;   // 8,192 rows per bank
  localparam int COL_W = 9;    // 512 columns per row
  localparam int DQ_W = 16;    // Data width
  localparam int LANES = 2;    // Byte lanes, one mask bit each
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int MODE_W = 13;  // Operation mode setting width

  // Operation mode setting field positions
  localparam int BURST_LEN_LSB = 0;
  localparam int BURST_LEN_MSB = 2;
  localparam int BURST_ORDER_BIT = 3;
  localparam int READ_LAT_LSB = 4;
  localparam int READ_LAT_MSB = 6;
  localparam int OP_MODE_LSB = 7;
  localparam int OP_MODE_MSB = 8;
  localparam int WRITE_BURST_POLICY_BIT = 9;

  // Address bit that selects auto precharge or all banks
  localparam int AUTO_PRE_BIT = 10;

  // Contents are undefined at power-up; a known value keeps simulation clean
  localparam logic [MODE_W-1:0] MODE_RESET = 13'h0000;

  // Burst length encodings
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Read latency encoding for three clocks; anything else runs as two
  localparam logic [2:0] READ_LAT_3 = 3'h3;

  // Auto precharge lead ahead of the last read output, in cycles
  localparam int LAST_OUT_TO_AUTOPRECHARGE_CL3 = 2;
  localparam int LAST_OUT_TO_AUTOPRECHARGE_CL2 = 1;
  localparam logic [1:0] AP_WAIT_CL3 = 2'(3 - LAST_OUT_TO_AUTOPRECHARGE_CL3 - 1);
  localparam logic [1:0] AP_WAIT_CL2 = 2'(2 - LAST_OUT_TO_AUTOPRECHARGE_CL2 - 1);

  // Decoded commands
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_BST, CMD_PRE, CMD_REF, CMD_LOAD
  } sdc_cmd_e;

  // Command and address pins sampled on the rising edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_high;
    logic bank_select_low;
    logic [ROW_W-1:0] addr;
    logic [LANES-1:0] dqm;
  } sdc_bus_s;

  // Complete state of the core
  typedef struct packed {
    logic [MODE_W-1:0] mode;             // Operation mode setting
    logic [3:0] open;                    // Row open per bank
    logic [3:0][ROW_W-1:0] row;          // Open row per bank
    logic busy;                          // Burst in progress
    logic wr;                            // Burst is a write
    logic ap;                            // Burst closes its row at the end
    logic [BANK_W-1:0] bank;             // Burst bank
    logic [COL_W-1:0] scol;              // Burst starting column
    logic [COL_W-1:0] idx;               // Next beat index
    logic p1_v;                          // First read stage
    logic [DQ_W-1:0] p1_d;
    logic p2_v;                          // Extra stage for latency three
    logic [DQ_W-1:0] p2_d;
    logic [LANES-1:0] dqm_d;             // Mask delayed one edge
    logic [DQ_W-1:0] out_d;              // Output data register
    logic [LANES-1:0] out_oe_n;          // Output enable per lane, low drives
    logic apc_v;                         // Read auto precharge pending
    logic [1:0] apc_cnt;
    logic [BANK_W-1:0] apc_bank;
  } sdc_state_s;

endpackage : sdc_pkg

// ==== tb/sdc_ctl_model.sv ====
// Memory controller model driving the command, mask and write data pins
module sdc_ctl_model (
  // Clock
  input wire logic mclk_i,
  // Pins towards the device
  output logic cke_o,
  output sdc_pkg::sdc_bus_s bus_o,
  output logic [sdc_pkg::DQ_W-1:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Powered clock enable and a deselected bus from time zero
  initial begin
    cke_o = 1'b1;
    bus_o = '1;
    dq_o = 16'h0000;
  end

  // One command per edge: set just after an edge, held up to the taking edge
  task automatic cmd(input logic [3:0] op, input logic [12:0] a, input logic [1:0] m,
                     input logic [15:0] d);
    // Bank one carries all traffic, so activates never meet another bank
    bus_o = {op, 2'h1, a, m};
    dq_o = d;
    @(posedge mclk_i);
    #1;
  endtask : cmd

  // No operation; released data lines show the inverse of their last value
  task automatic idle();
    cmd(4'h7, 13'h0000, 2'h0, ~dq_o);
  endtask : idle
endmodule : sdc_ctl_model

// ==== tb/sdc_sdram_core_tb_top.sv ====
// Self-checking bench for the SDRAM core
module sdc_sdram_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cke;
  sdc_pkg::sdc_bus_s bus;
  logic [15:0] dq_in, dq_out;
  logic [1:0] oe_n;
  logic [15:0] mem [512]; // Expected contents of the open row
  logic [12:0] modes [7] = '{13'h0222, 13'h0022, 13'h003B, 13'h0021, 13'h0030, 13'h0037, 13'h0033};
  logic [8:0] starts [7] = '{9'h004, 9'h009, 9'h00D, 9'h003, 9'h006, 9'h1FE, 9'h005};
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 mclk_i = ~mclk_i;
  sdc_ctl_model ctl (.mclk_i(mclk_i), .cke_o(cke), .bus_o(bus), .dq_o(dq_in));
  sdc_sdram_core DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cke_i(cke), .bus_i(bus),
    .dq_i(dq_in), .dq_o(dq_out), .dq_oe_n_o(oe_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Reload the mode with all banks idle, then reopen bank one, row five
  task automatic set_mode(input logic [12:0] m);
    ctl.cmd(4'h2, 13'h0400, 2'h0, 16'h0000);
    ctl.cmd(4'h0, m, 2'h0, 16'h0000);
    repeat (2) ctl.idle();
    ctl.cmd(4'h3, 13'h0005, 2'h0, 16'h0000);
    repeat (2) ctl.idle();
  endtask : set_mode
  // Read a burst and compare every beat (only the first four of a full page), then the float after a fixed burst
  // Beat k stands from just after edge read+latency-1+k, so it is looked at one edge early
  task automatic read_check(input logic [12:0] m, input logic [8:0] s);
    int cl, n, l, k, b, c;
    cl = m[6:4] == 3'h3 ? 3 : 2;
    n = m[2:0] == 3'h7 ? 4 : 1 << m[2:0];
    l = m[2:0] == 3'h7 ? 512 : n;
    b = s & ~(l - 1);
    ctl.cmd(4'h5, {4'h0, s}, 2'h0, 16'h0000);
    for (int j = 0; j < cl + n; j++) begin
      ctl.idle();
      k = j - cl + 2;
      if (k == n && m[2:0] != 3'h7) begin
        check({14'h0000, oe_n}, 16'h0003);
      end else if (k >= 0 && k < n) begin
        c = b | ((m[3] ? s ^ k : s + k) & (l - 1));
        check(dq_out, mem[9'(c)]);
      end
    end
  endtask : read_check
  // Ceiling on the run length
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 15000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    repeat (10000) ctl.idle();
    ctl.cmd(4'h2, 13'h0400, 2'h0, 16'h0000);
    repeat (2) begin
      ctl.cmd(4'h1, 13'h0000, 2'h0, 16'h0000);
      repeat (6) ctl.idle();
    end
    set_mode(13'h0020);
    // Single writes on every cycle fill the whole row
    for (int c = 0; c < 512; c++) begin
      mem[c] = 16'hA000 + 16'(c);
      ctl.cmd(4'h4, 13'(c), 2'h0, mem[c]);
    end
    mem[2] = 16'hFF02;
    ctl.cmd(4'h4, 13'h0002, 2'h1, 16'hFFFF);
    set_mode(13'h0022);
    mem[8] = 16'h1111;
    mem[9] = 16'h2222;
    ctl.cmd(4'h4, 13'h0008, 2'h0, 16'h1111);
    ctl.cmd(4'h7, 13'h0000, 2'h0, 16'h2222);
    ctl.cmd(4'h6, 13'h0000, 2'h0, 16'h3333);
    mem[12] = 16'h4444;
    ctl.cmd(4'h4, 13'h000C, 2'h0, 16'h4444);
    ctl.cmd(4'h2, 13'h0000, 2'h0, 16'h5555);
    set_mode(13'h0222);
    mem[4] = 16'h1234;
    ctl.cmd(4'h4, 13'h0004, 2'h0, 16'h1234);
    ctl.cmd(4'h7, 13'h0000, 2'h0, 16'h9999);
    $display("test writes done");
    // Each mode in turn; the full page burst is ended by a stop
    for (int i = 0; i < 7; i++) begin
      set_mode(modes[i]);
      read_check(modes[i], starts[i]);
      if (modes[i][2:0] == 3'h7) ctl.cmd(4'h6, 13'h0000, 2'h0, 16'h0000);
      $display("test read %0d done", i);
    end
    repeat (4) ctl.idle();
    complete_run();
  end
endmodule : sdc_sdram_core_tb_top

// ==== tb/sdc_sdram_props.sv ====
// Pin-level checks of the SDRAM core
module sdc_sdram_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Watched pins
  input wire logic cke_i,
  input wire sdc_pkg::sdc_bus_s bus_i,
  input wire logic [sdc_pkg::DQ_W-1:0] dq_i,
  input wire logic [sdc_pkg::DQ_W-1:0] dq_o,
  input wire logic [sdc_pkg::LANES-1:0] dq_oe_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] op; // Strobe nibble
  logic [1:0] bk; // Addressed bank
  logic [12:0] mode_r; // Mirror of the mode setting
  logic [3:0] open_r; // Banks known open; auto precharge clears early to stay safe
  logic cl3, rd;
  assign op = {bus_i.cs_n, bus_i.ras_n, bus_i.cas_n, bus_i.we_n};
  assign bk = {bus_i.bank_select_high, bus_i.bank_select_low};
  assign cl3 = mode_r[6:4] == 3'h3;
  assign rd = cke_i && op == 4'h5 && open_r[bk];
  // Track loads and row opens so reads can be judged
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= 13'h0000;
      open_r <= 4'h0;
    end else if (cke_i) begin
      if (op == 4'h0) mode_r <= bus_i.addr;
      if (op == 4'h3) open_r[bk] <= 1'b1;
      if (op == 4'h2 || (op[3:1] == 3'h2 && bus_i.addr[10])) open_r <= 4'h0;
    end
  end
  a_reset_floats: assert property ($rose(rst_n_i) |-> dq_oe_n_o == 2'h3)
    else $error("pins driven after reset");
  a_read_lat_two: assert property (rd && !cl3 && bus_i.dqm == 2'h0 ##1 cke_i
    |-> ##1 dq_oe_n_o == 2'h0) else $error("read data late at latency two");
  a_read_lat_three: assert property (rd && cl3 ##1 cke_i && bus_i.dqm == 2'h0 ##1 cke_i
    |-> ##1 dq_oe_n_o == 2'h0) else $error("read data late at latency three");
  a_mask_low_lane: assert property (bus_i.dqm[0] && cke_i ##1 cke_i
    |-> ##1 dq_oe_n_o[0]) else $error("low lane driven under mask");
  a_mask_high_lane: assert property (bus_i.dqm[1] && cke_i ##1 cke_i
    |-> ##1 dq_oe_n_o[1]) else $error("high lane driven under mask");
  a_stop_float_two: assert property (cke_i && op == 4'h6 && !cl3 ##1 cke_i[*2]
    |-> dq_oe_n_o == 2'h3) else $error("outputs not floated after stop");
  a_stop_float_three: assert property (cke_i && op == 4'h6 && cl3 ##1 cke_i[*3]
    |-> dq_oe_n_o == 2'h3) else $error("outputs not floated after stop");
  a_pre_float_two: assert property (cke_i && op == 4'h2 && bus_i.addr[10] && !cl3
    ##1 cke_i[*2] |-> dq_oe_n_o == 2'h3) else $error("outputs not floated after precharge");
  a_pre_float_three: assert property (cke_i && op == 4'h2 && bus_i.addr[10] && cl3
    ##1 cke_i[*3] |-> dq_oe_n_o == 2'h3) else $error("outputs not floated after precharge");
endmodule : sdc_sdram_props

bind sdc_sdram_core sdc_sdram_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cke_i(cke_i),
  .bus_i(bus_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
